// *** rni_pkg.sv ***
package rni_pkg;
	// 14-bit instruction word encodings
	localparam int INSTR_W = 14;
	localparam logic [13:0] OPC_NO_OPERATION_INSTR = 14'h0000;
	localparam logic [13:0] OPC_RETURN_FROM_INTERRUPT_INSTR = 14'h0009;
	localparam logic [13:0] OPC_RETURN = 14'h0008;
	localparam logic [5:0] OPC_RETURN_WITH_LITERAL_HI = 6'h0d;
	localparam int RETURN_WITH_LITERAL_HI_POS = 8;
	localparam int LIT_W = 8;
	localparam int PC_W = 13;
	localparam int GLOBAL_INTERRUPT_ENABLE_POS = 7;
	localparam logic [7:0] INTCTL_RESET = 8'h00;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam int STACK_DEPTH = 8;
	localparam int RET_CYCLES = 2;
	localparam int NOP_CYCLES = 1;

	typedef enum logic [2:0] {
		RNI_FETCH = 3'b001,
		RNI_FLUSH = 3'b010,
		RNI_IDLE = 3'b100
	} rni_state_t;
endpackage : rni_pkg

// *** rni_ret_stack.sv ***
`timescale 1ns/1ns
module rni_ret_stack #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] top_of_return_stack,
	output logic [$clog2(DEPTH)-1:0] ptr
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [$clog2(DEPTH)-1:0] ptr_reg;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("stack depth must be a power of two");
	end

	// circular stack: overflow wraps silently, as in the core
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ptr_reg <= '0;
		else if (push)
			ptr_reg <= ptr_reg + 1'b1;
		else if (pop)
			ptr_reg <= ptr_reg - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[ptr_reg] <= push_data;
	end

	assign top_of_return_stack = mem_reg[ptr_reg - 1'b1];
	assign ptr = ptr_reg;
endmodule : rni_ret_stack

// *** rni_core.sv ***
`timescale 1ns/1ns
// Function
// - return from interrupt pops the return stack top entry.
// - return from interrupt loads the program counter from the stack top.
// - return from interrupt sets global interrupt enable, control bit 7.
// - return from interrupt takes two cycles and one program word.
// - literal return writes the 8-bit literal into the working register.
// - literal return pops the stack and loads the program counter.
// - literal return completes in two cycles.
module rni_core #(
	parameter int STACK_DEPTH = rni_pkg::STACK_DEPTH
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic INSTR_VALID,
	input wire logic [13:0] INSTR,
	input wire logic CALL_PUSH,
	input wire logic [12:0] CALL_TARGET,
	input wire logic INT_EN_CLEAR,
	output logic [12:0] PC,
	output logic [7:0] W,
	output logic [7:0] INTCTL,
	output logic [12:0] TOP_OF_STACK,
	output logic [$clog2(STACK_DEPTH)-1:0] STACK_PTR,
	output logic BUSY
);
	rni_pkg::rni_state_t state_reg;
	rni_pkg::rni_state_t state_next;
	logic [12:0] pc_reg;
	logic [7:0] w_reg;
	logic [7:0] intctl_reg;
	logic dec_no_operation;
	logic dec_return_from_interrupt;
	logic dec_return_with_literal;
	logic dec_return;
	logic take;
	logic pop;
	logic [12:0] top_of_return_stack;

	// the pointer port is sized from the depth, so only powers of two fit
	if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("core stack depth must be a power of two of at least two");
	end

	// an instruction offered in the flush cycle is dropped without a sign
	assign take = INSTR_VALID && state_reg == rni_pkg::RNI_FETCH;
	assign dec_no_operation = INSTR == rni_pkg::OPC_NO_OPERATION_INSTR;
	assign dec_return_from_interrupt = INSTR == rni_pkg::OPC_RETURN_FROM_INTERRUPT_INSTR;
	assign dec_return = INSTR == rni_pkg::OPC_RETURN;
	assign dec_return_with_literal =
		INSTR[13:rni_pkg::RETURN_WITH_LITERAL_HI_POS] == rni_pkg::OPC_RETURN_WITH_LITERAL_HI;
	assign pop = take && (dec_return_from_interrupt || dec_return_with_literal || dec_return);
	// a push meeting a pop is dropped: the pop owns the pointer that cycle

	rni_ret_stack #(
		.WIDTH(rni_pkg::PC_W),
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.clk(CLK),
		.rst_b(RST_B),
		.push(CALL_PUSH && !pop),
		.push_data(CALL_TARGET),
		.pop(pop),
		.top_of_return_stack(top_of_return_stack),
		.ptr(STACK_PTR)
	);

	// the idle code is never entered; the default branch pulls it back
	// flush cycle
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			rni_pkg::RNI_FETCH:
				if (pop)
					state_next = rni_pkg::RNI_FLUSH;
			rni_pkg::RNI_FLUSH:
				state_next = rni_pkg::RNI_FETCH;
			default:
				state_next = rni_pkg::RNI_FETCH;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			state_reg <= rni_pkg::RNI_FETCH;
		else
			state_reg <= state_next;
	end

	// unknown codes fall through to the plain advance
	// program counter update
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			pc_reg <= rni_pkg::PC_RESET;
		else if (pop)
			pc_reg <= top_of_return_stack;
		else if (take)
			pc_reg <= pc_reg + 13'h0001;
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			w_reg <= rni_pkg::W_RESET;
		else if (take && dec_return_with_literal)
			w_reg <= INSTR[rni_pkg::LIT_W-1:0];
	end

	// an entry clear in the return's own cycle loses, so the return never masks itself
	// set beats clear
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			intctl_reg <= rni_pkg::INTCTL_RESET;
		else if (take && dec_return_from_interrupt)
			intctl_reg[rni_pkg::GLOBAL_INTERRUPT_ENABLE_POS] <= 1'b1;
		else if (INT_EN_CLEAR)
			intctl_reg[rni_pkg::GLOBAL_INTERRUPT_ENABLE_POS] <= 1'b0;
	end

	assign PC = pc_reg;
	assign W = w_reg;
	assign INTCTL = intctl_reg;
	assign TOP_OF_STACK = top_of_return_stack;
	assign BUSY = state_reg == rni_pkg::RNI_FLUSH;

	sequence ret_taken_s;
		take && (dec_return_from_interrupt || dec_return_with_literal);
	endsequence

	sequence flush_then_fetch_s;
		BUSY ##1 !BUSY;
	endsequence

	sequence popped_s;
		STACK_PTR == $past(STACK_PTR) - 1'b1;
	endsequence

	sequence pc_from_top_s;
		PC == $past(top_of_return_stack);
	endsequence

	property two_cycle_p;
		@(posedge CLK) disable iff (!RST_B)
		ret_taken_s |=> flush_then_fetch_s;
	endproperty

	ret_two_cycle_a: assert property (two_cycle_p)
		else $error("return did not take two cycles");

	lit_ret_cycles_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_with_literal |=> flush_then_fetch_s)
		else $error("literal return not two cycles");

	int_ret_pop_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_from_interrupt && !CALL_PUSH |=> popped_s)
		else $error("return from interrupt did not pop");

	int_ret_pc_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_from_interrupt |=> pc_from_top_s)
		else $error("pc not loaded from stack top");

	enable_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_from_interrupt |=> INTCTL[rni_pkg::GLOBAL_INTERRUPT_ENABLE_POS])
		else $error("global enable not set");

	lit_load_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_with_literal |=> W == $past(INSTR[7:0]))
		else $error("literal not loaded");

	lit_ret_pc_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return_with_literal && !CALL_PUSH |=> pc_from_top_s ##0 popped_s)
		else $error("literal return pc or pop wrong");

	no_op_state_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_no_operation && !CALL_PUSH && !INT_EN_CLEAR |=> PC == $past(PC) + 13'h0001
		&& $stable(W) && $stable(INTCTL) && $stable(STACK_PTR) && !BUSY)
		else $error("no-operation changed state");

	flush_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
		BUSY && !CALL_PUSH |=> $stable(PC) && $stable(W) && $stable(STACK_PTR))
		else $error("instruction in flush cycle took effect");

	busy_one_cycle_a: assert property (@(posedge CLK) disable iff (!RST_B)
		BUSY |=> !BUSY)
		else $error("flush lasted more than one cycle");

	enable_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
		!(take && dec_return_from_interrupt) && !INT_EN_CLEAR |=> $stable(INTCTL))
		else $error("interrupt control changed without cause");

	spare_bits_a: assert property (@(posedge CLK) disable iff (!RST_B)
		INTCTL[6:0] == 7'h00)
		else $error("spare interrupt control bits not zero");

	other_op_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && !pop |=> PC == $past(PC) + 13'h0001 && !BUSY)
		else $error("non-return instruction did not advance");

	// plain return pops and loads the pc like the literal return
	plain_ret_a: assert property (@(posedge CLK) disable iff (!RST_B)
		take && dec_return && !CALL_PUSH |=> pc_from_top_s ##0 popped_s)
		else $error("plain return pc or pop wrong");
endmodule : rni_core

// *** test_return_and_nop_instr_exec.sv ***
`timescale 1ns/1ns
module test_return_and_nop_instr_exec;
	logic CLK = 1'b0, RST_B = 1'b0, INSTR_VALID = 1'b0, CALL_PUSH = 1'b0, INT_EN_CLEAR = 1'b0;
	logic [13:0] INSTR = 14'h0000;
	logic [12:0] CALL_TARGET = 13'h0000, PC, TOP_OF_STACK;
	logic [7:0] W, INTCTL;
	logic [2:0] STACK_PTR;
	logic BUSY;
	int err_total = 0, compares = 0, sp = 0, pc = 0, w = 0, ie = 0, k, c;
	int stk[8];
	always #50 CLK = ~CLK;
	rni_core i_dut (.CLK(CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.CALL_PUSH(CALL_PUSH), .CALL_TARGET(CALL_TARGET), .INT_EN_CLEAR(INT_EN_CLEAR), .PC(PC),
		.W(W), .INTCTL(INTCTL), .TOP_OF_STACK(TOP_OF_STACK), .STACK_PTR(STACK_PTR), .BUSY(BUSY));
	task chk(string n, logic [12:0] seen, logic [12:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// push stand-in for a call
	task push(int t);
		@(posedge CLK);
		CALL_PUSH <= 1'b1;
		CALL_TARGET <= 13'(t);
		@(posedge CLK);
		CALL_PUSH <= 1'b0;
		stk[sp] = t;
		sp = (sp + 1) % 8;
		@(negedge CLK);
		chk("tos", TOP_OF_STACK, 13'(t));
	endtask : push
	// an unknown code 14'h34aa is offered in the busy cycle after a return and must be ignored
	task run(logic [13:0] op);
		bit ret;
		ret = (op != 14'h0000);
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= op;
		INT_EN_CLEAR <= c[0];
		@(posedge CLK);
		INSTR <= 14'h34aa;
		INSTR_VALID <= ret;
		INT_EN_CLEAR <= 1'b0;
		if (ret)
		begin
			sp = (sp + 7) % 8;
			pc = stk[sp];
		end
		else
			pc = (pc + 1) % 8192;
		if (op[13:8] === 6'h0d)
			w = op[7:0];
		if (op === 14'h0009)
			ie = 1;
		else if (c)
			ie = 0;
		@(negedge CLK);
		chk("pc", PC, 13'(pc));
		chk("w", {5'h00, W}, 13'(w));
		chk("intctl", {5'h00, INTCTL}, 13'(ie * 128));
		chk("sp", {10'h000, STACK_PTR}, 13'(sp));
		chk("busy", {12'h000, BUSY}, 13'(ret));
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		@(negedge CLK);
		chk("busy", {12'h000, BUSY}, 13'h0000);
		chk("pc", PC, 13'(pc));
		chk("w", {5'h00, W}, 13'(w));
	endtask : run
	initial
	begin
		#1000000;
		err_total++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(37));
		repeat (8) @(posedge CLK);
		RST_B <= 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			push($urandom % 8192);
			push($urandom % 8192);
			push($urandom % 8192);
			c = i % 2;
			run(14'h0000);
			k = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
			run(i % 2 ? {6'h0d, k[7:0]} : 14'h0009);
			run(i % 2 ? 14'h0009 : {6'h0d, k[7:0]});
			run(14'h0008);
			run(14'h0000);
			$display("test %0d done", i);
		end
		end_of_test();
	end
endmodule : test_return_and_nop_instr_exec
